// ==== core/sdp_pkg.sv ====
// Constants, register indices and types of the split dual 8-bit PWM timer.
// Assumes a classic Wishbone host with 32-bit data and one register per aligned word.
//
// Functional notes
// - Four-bit select: off, seven prescales, eight events.
// - After reset no clock, counters stand still.
// - One clock selection drives both counters.
// - Count down to zero, then reload period.
// - Bus count write beats counting and reloading.
// - New period used only at next reload.
// - Low match sets flag next clock, emits event.
// - High matches drive waveforms only, no flags.
// - Waveform set on match, cleared at zero.
// - Low channels pins 0-3, high 4-7.
// - Channel enable replaces port output register value.
// - Underflow flags; every flag condition emits event.
// - Flags request DMA; matching DMA access acknowledges, a DMA write for underflow flags.
// - Restart zeroes counter and its waveform outputs.
// - Reset command restores registers, only when off.
// - While off, output value writes set waveforms.
// - Mode field: normal, byte, split, reserved.
// - Flags clear on vector acknowledge or written one.
// - Command target low, high, both; reads zero.
`default_nettype none

package sdp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] SDP_IDX_CLK = 6'h00;
  localparam logic [5:0] SDP_IDX_OEN = 6'h01;
  localparam logic [5:0] SDP_IDX_OVAL = 6'h02;
  localparam logic [5:0] SDP_IDX_MODE = 6'h04;
  localparam logic [5:0] SDP_IDX_CMD = 6'h09;
  localparam logic [5:0] SDP_IDX_FLAGS = 6'h0C;
  localparam logic [5:0] SDP_IDX_LCNT = 6'h20;
  localparam logic [5:0] SDP_IDX_HCNT = 6'h21;
  localparam logic [5:0] SDP_IDX_LPER = 6'h26;
  localparam logic [5:0] SDP_IDX_HPER = 6'h27;
  localparam logic [5:0] SDP_IDX_CMP0 = 6'h28;
  localparam logic [5:0] SDP_IDX_CMP_LAST = 6'h2F;

  // ----------------------------------------------------------------
  // Field positions and values after reset
  // ----------------------------------------------------------------
  localparam int SDP_FLAG_LUNF = 0;
  localparam int SDP_FLAG_HUNF = 1;
  localparam int SDP_FLAG_CMP0 = 4;
  localparam logic [7:0] SDP_FLAG_MASK = 8'hF3;
  localparam logic [3:0] SDP_CLK_OFF = 4'h0;
  localparam logic [7:0] SDP_CNT_RST = 8'h00;
  localparam logic [7:0] SDP_PER_RST = 8'hFF;
  localparam logic [7:0] SDP_CMP_RST = 8'h00;
  localparam int SDP_PRE_W = 10;

  // ----------------------------------------------------------------
  // Modes, commands and targets
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDP_MODE_NORMAL = 2'b00,
    SDP_MODE_BYTE = 2'b01,
    SDP_MODE_SPLIT = 2'b10,
    SDP_MODE_RSVD = 2'b11
  } sdp_mode_t;

  typedef enum logic [1:0] {
    SDP_CMD_NONE = 2'b00,
    SDP_CMD_RSVD = 2'b01,
    SDP_CMD_RESTART = 2'b10,
    SDP_CMD_RESET = 2'b11
  } sdp_cmd_t;

  localparam logic [1:0] SDP_TGT_LOW = 2'b01;
  localparam logic [1:0] SDP_TGT_HIGH = 2'b10;

  // ----------------------------------------------------------------
  // Wishbone request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sdp_wb_req_t;

endpackage

`default_nettype wire

// ==== core/sdp_timer.sv ====
// Split dual 8-bit PWM timer with Wishbone register access and port override.
// Assumes the prescaler taps, event pulses and port registers are on clk_i.
//
// Chosen here: register access over Wishbone and the register offsets.
`default_nettype none

module sdp_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire sdp_pkg::sdp_wb_req_t wb_req_i,
  input wire logic wb_dma_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Event channels and interrupt vector acknowledge
  input wire logic [7:0] evt_i,
  input wire logic [7:0] irq_ack_i,
  // Port pins
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] port_dir_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  // Events and DMA requests
  output logic evt_low_unf_o,
  output logic evt_high_unf_o,
  output logic [3:0] evt_cmp_o,
  output logic [7:0] dma_req_o
);
  import sdp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sdp_dec(input logic [7:0] cnt, input logic [7:0] per);
    sdp_dec = (cnt == 8'h00) ? per : cnt - 8'h01;
  endfunction

  function automatic logic [SDP_PRE_W-1:0] sdp_pre_mask(input logic [2:0] code);
    case (code)
      3'h2: sdp_pre_mask = 10'h001;
      3'h3: sdp_pre_mask = 10'h003;
      3'h4: sdp_pre_mask = 10'h007;
      3'h5: sdp_pre_mask = 10'h03F;
      3'h6: sdp_pre_mask = 10'h0FF;
      3'h7: sdp_pre_mask = 10'h3FF;
      default: sdp_pre_mask = 10'h000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [3:0] clk_r;
  logic [7:0] oen_r;
  sdp_mode_t mode_r;
  logic [7:0] lcnt_r, lcnt_nxt, hcnt_r, hcnt_nxt;
  logic [7:0] lper_r, hper_r;
  logic [7:0] lcmp_r [4];
  logic [7:0] hcmp_r [4];
  logic [7:0] wave_r, wave_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [SDP_PRE_W-1:0] pre_r;
  logic evl_r, evh_r;
  logic [3:0] evc_r;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req = wb_req_i.cyc && wb_req_i.stb;
  wire logic acc = req && ack_r;
  wire logic wr = acc && wb_req_i.we && wb_req_i.sel[0];
  wire logic [5:0] idx = wb_req_i.adr[7:2];
  wire logic [7:0] wdat = wb_req_i.dat[7:0];
  wire logic is_off = (clk_r == SDP_CLK_OFF);
  wire logic cmp_hit = (idx >= SDP_IDX_CMP0) && (idx <= SDP_IDX_CMP_LAST);
  wire logic [2:0] cmp_sel = 3'(idx - SDP_IDX_CMP0);
  wire logic wr_lcnt = wr && (idx == SDP_IDX_LCNT);
  wire logic wr_hcnt = wr && (idx == SDP_IDX_HCNT);
  wire logic wr_cmd = wr && (idx == SDP_IDX_CMD);
  wire logic [1:0] cmd_tgt = wdat[1:0];
  wire logic cmd_restart = wr_cmd && (sdp_cmd_t'(wdat[3:2]) == SDP_CMD_RESTART);
  wire logic restart_l = cmd_restart && cmd_tgt[0];
  wire logic restart_h = cmd_restart && cmd_tgt[1];
  wire logic soft_rst = wr_cmd && (sdp_cmd_t'(wdat[3:2]) == SDP_CMD_RESET) && (cmd_tgt != 2'b00) && is_off;
  wire logic rst_all = rst_i || soft_rst;

  // ----------------------------------------------------------------
  // Clock selection and prescaler
  // ----------------------------------------------------------------
  wire logic [SDP_PRE_W-1:0] pre_mask = sdp_pre_mask(clk_r[2:0]);
  wire logic pre_tick = ((pre_r & pre_mask) == pre_mask);
  wire logic tick = clk_r[3] ? evt_i[clk_r[2:0]] : (!is_off && pre_tick);
  wire logic split = (mode_r == SDP_MODE_SPLIT);
  wire logic tick_run = tick && (mode_r != SDP_MODE_RSVD);
  wire logic [15:0] cnt16 = {hcnt_r, lcnt_r};
  wire logic [15:0] cnt16_nxt = (cnt16 == 16'h0000) ? {hper_r, lper_r} : cnt16 - 16'h0001;
  wire logic l_bot = split ? (lcnt_r == 8'h00) : (cnt16 == 16'h0000);
  wire logic h_bot = (hcnt_r == 8'h00);
  wire logic unf_l = tick_run && l_bot;
  wire logic unf_h = tick_run && split && h_bot;

  // ----------------------------------------------------------------
  // Compare units
  // ----------------------------------------------------------------
  logic [3:0] lmatch, hmatch, cmp_ev, dma_cmp_clr;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lmatch[i] = (lcnt_r == lcmp_r[i]);
      hmatch[i] = (hcnt_r == hcmp_r[i]);
      cmp_ev[i] = tick_run && lmatch[i];
      dma_cmp_clr[i] = acc && wb_dma_i && (idx == SDP_IDX_CMP0 + 6'(2 * i));
    end
  end

  // ----------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------
  always_comb begin
    lcnt_nxt = lcnt_r;
    hcnt_nxt = hcnt_r;
    if (tick_run) begin
      if (split) begin
        lcnt_nxt = sdp_dec(lcnt_r, lper_r);
        hcnt_nxt = sdp_dec(hcnt_r, hper_r);
      end else begin
        {hcnt_nxt, lcnt_nxt} = cnt16_nxt;
        if (mode_r == SDP_MODE_BYTE) begin
          hcnt_nxt = 8'h00;
        end
      end
    end
    if (restart_l) begin
      lcnt_nxt = 8'h00;
    end
    if (restart_h) begin
      hcnt_nxt = 8'h00;
    end
    if (wr_lcnt) begin
      lcnt_nxt = wdat;
    end
    if (wr_hcnt) begin
      hcnt_nxt = wdat;
    end
  end

  // ----------------------------------------------------------------
  // Waveform generators
  // ----------------------------------------------------------------
  always_comb begin
    wave_nxt = wave_r;
    if (tick_run) begin
      for (int i = 0; i < 4; i++) begin
        if (l_bot) begin
          wave_nxt[i] = 1'b0;
        end else if (lmatch[i]) begin
          wave_nxt[i] = 1'b1;
        end
        if (h_bot) begin
          wave_nxt[i + 4] = 1'b0;
        end else if (hmatch[i]) begin
          wave_nxt[i + 4] = 1'b1;
        end
      end
    end
    if (restart_l) begin
      wave_nxt[3:0] = 4'h0;
    end
    if (restart_h) begin
      wave_nxt[7:4] = 4'h0;
    end
    if (wr && (idx == SDP_IDX_OVAL) && is_off) begin
      wave_nxt = wdat;
    end
  end

  // ----------------------------------------------------------------
  // Flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  logic [7:0] flag_set, flag_clr;
  always_comb begin
    flag_set = 8'h00;
    flag_set[SDP_FLAG_LUNF] = unf_l;
    flag_set[SDP_FLAG_HUNF] = unf_h;
    flag_set[SDP_FLAG_CMP0 +: 4] = cmp_ev;
    flag_clr = irq_ack_i;
    if (wr && (idx == SDP_IDX_FLAGS)) begin
      flag_clr = flag_clr | wdat;
    end
    if (acc && wb_dma_i && wb_req_i.we && ((idx == SDP_IDX_LCNT) || (idx == SDP_IDX_LPER))) begin
      flag_clr[SDP_FLAG_LUNF] = 1'b1;
    end
    if (acc && wb_dma_i && wb_req_i.we && ((idx == SDP_IDX_HCNT) || (idx == SDP_IDX_HPER))) begin
      flag_clr[SDP_FLAG_HUNF] = 1'b1;
    end
    flag_clr[SDP_FLAG_CMP0 +: 4] = flag_clr[SDP_FLAG_CMP0 +: 4] | dma_cmp_clr;
    flags_nxt = ((flags_r & ~flag_clr) | flag_set) & SDP_FLAG_MASK;
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      SDP_IDX_CLK: rd_data[3:0] = clk_r;
      SDP_IDX_OEN: rd_data[7:0] = oen_r;
      SDP_IDX_OVAL: rd_data[7:0] = wave_r;
      SDP_IDX_MODE: rd_data[1:0] = mode_r;
      SDP_IDX_CMD: rd_data = 32'h0000_0000;
      SDP_IDX_FLAGS: rd_data[7:0] = flags_r;
      SDP_IDX_LCNT: rd_data[7:0] = lcnt_r;
      SDP_IDX_HCNT: rd_data[7:0] = hcnt_r;
      SDP_IDX_LPER: rd_data[7:0] = lper_r;
      SDP_IDX_HPER: rd_data[7:0] = hper_r;
      default: begin
        if (cmp_hit) begin
          rd_data[7:0] = cmp_sel[0] ? hcmp_r[cmp_sel[2:1]] : lcmp_r[cmp_sel[2:1]];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      clk_r <= SDP_CLK_OFF;
      oen_r <= 8'h00;
      mode_r <= SDP_MODE_NORMAL;
      lper_r <= SDP_PER_RST;
      hper_r <= SDP_PER_RST;
    end else if (wr) begin
      case (idx)
        SDP_IDX_CLK: clk_r <= wdat[3:0];
        SDP_IDX_OEN: oen_r <= wdat;
        SDP_IDX_MODE: mode_r <= sdp_mode_t'(wdat[1:0]);
        SDP_IDX_LPER: lper_r <= wdat;
        SDP_IDX_HPER: hper_r <= wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      for (int i = 0; i < 4; i++) begin
        lcmp_r[i] <= SDP_CMP_RST;
        hcmp_r[i] <= SDP_CMP_RST;
      end
    end else if (wr && cmp_hit) begin
      if (cmp_sel[0]) begin
        hcmp_r[cmp_sel[2:1]] <= wdat;
      end else begin
        lcmp_r[cmp_sel[2:1]] <= wdat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters, waveforms, flags, events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      lcnt_r <= SDP_CNT_RST;
      hcnt_r <= SDP_CNT_RST;
      wave_r <= 8'h00;
      flags_r <= 8'h00;
      pre_r <= '0;
      evl_r <= 1'b0;
      evh_r <= 1'b0;
      evc_r <= 4'h0;
    end else begin
      lcnt_r <= lcnt_nxt;
      hcnt_r <= hcnt_nxt;
      wave_r <= wave_nxt;
      flags_r <= flags_nxt;
      pre_r <= pre_r + 10'h001;
      evl_r <= unf_l;
      evh_r <= unf_h;
      evc_r <= cmp_ev;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pin_o = (oen_r & wave_r) | (~oen_r & port_out_i);
  assign pin_oe_o = port_dir_i;
  assign evt_low_unf_o = evl_r;
  assign evt_high_unf_o = evh_r;
  assign evt_cmp_o = evc_r;
  assign dma_req_o = flags_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_off_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_off && !clk_r[3] && !wr_lcnt && !restart_l && !soft_rst) |=> (lcnt_r == $past(lcnt_r)))
    else $error("Low counter moved while the timer was off.");

  chk_reload_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_run && split && lcnt_r == 8'h00 && !wr_lcnt && !restart_l) |=> (lcnt_r == $past(lper_r)))
    else $error("Low counter did not reload its period at zero.");

  chk_dec_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_run && split && lcnt_r != 8'h00 && !wr_lcnt && !restart_l) |=> (lcnt_r == $past(lcnt_r) - 8'h01))
    else $error("Low counter did not count down by one.");

  chk_cnt_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hcnt |=> (hcnt_r == $past(wdat)))
    else $error("High count write was not taken at once.");

  chk_cmp_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmp_ev[0] && !soft_rst) |=> (flags_r[SDP_FLAG_CMP0] && evt_cmp_o[0]) ##1 (!evt_cmp_o[0] || $past(cmp_ev[0])))
    else $error("Low compare match gave no flag or event.");

  chk_wave_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_run && split && h_bot && !restart_h) |=> (wave_r[7:4] == 4'h0))
    else $error("High waveforms not cleared at zero.");

  chk_pin_override: assert property (@(posedge clk_i) disable iff (rst_i)
    (oen_r[4] && port_dir_i[4]) |-> (pin_oe_o[4] && pin_o[4] == wave_r[4]))
    else $error("Enabled channel does not drive its pin.");

  chk_unf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (unf_l && !soft_rst) |=> (flags_r[SDP_FLAG_LUNF] && evt_low_unf_o && dma_req_o[SDP_FLAG_LUNF]))
    else $error("Low underflow gave no flag, event or request.");

  chk_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (restart_l && !wr_lcnt) |=> (lcnt_r == 8'h00 && wave_r[3:0] == 4'h0))
    else $error("Restart did not zero the low counter and outputs.");

  chk_cmd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_r && idx == SDP_IDX_CMD) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
    else $error("Command register did not read as zero.");

  chk_reset_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_rst |=> (clk_r == SDP_CLK_OFF && oen_r == 8'h00 && lper_r == SDP_PER_RST && flags_r == 8'h00))
    else $error("Reset command did not restore the registers.");

  chk_high_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_run && split && hcnt_r != 8'h00 && !wr_hcnt && !restart_h) |=> (hcnt_r == $past(hcnt_r) - 8'h01))
    else $error("High counter did not count on the shared clock.");

  chk_high_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_run && (hmatch != 4'h0) && (lmatch == 4'h0)) |=> (evt_cmp_o == 4'h0))
    else $error("High compare match raised a compare event.");

  chk_high_unf: assert property (@(posedge clk_i) disable iff (rst_i)
    (unf_h && !soft_rst) |=> (flags_r[SDP_FLAG_HUNF] && evt_high_unf_o && dma_req_o[SDP_FLAG_HUNF]))
    else $error("High underflow gave no flag, event or request.");

  chk_vector_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_ack_i[SDP_FLAG_CMP0] && !cmp_ev[0]) |=> !flags_r[SDP_FLAG_CMP0])
    else $error("Vector acknowledge did not clear the compare flag.");

  chk_oval_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == SDP_IDX_OVAL && !is_off && !tick_run) |=> (wave_r == $past(wave_r)))
    else $error("Output value write changed waveforms while running.");

endmodule

`default_nettype wire

// ==== bench/sdp_far_model.sv ====
// Far-side model: event channels and the port registers around the timer pins.
// Assumes it runs on the timer clock and is driven by the bench just after rising edges.
`default_nettype none

module sdp_far_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic fire_i,
  input wire logic [2:0] ch_i,
  input wire logic [7:0] out_val_i,
  input wire logic [7:0] dir_val_i,
  // Toward the timer
  output logic [7:0] evt_o,
  output logic [7:0] port_out_o,
  output logic [7:0] port_dir_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // One-cycle pulse on the chosen event channel.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_o <= 8'h00;
    end else begin
      evt_o <= fire_i ? (8'h01 << ch_i) : 8'h00;
    end
  end

  // Port output and direction registers.
  always_ff @(posedge clk_i) begin
    port_out_o <= rst_i ? 8'h00 : out_val_i;
    port_dir_o <= rst_i ? 8'h00 : dir_val_i;
  end
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the split dual 8-bit PWM timer.
// Assumes sdp_pkg, sdp_timer and sdp_far_model are compiled before it.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdp_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sdp_wb_req_t wb_req = '0;
  logic wb_dma = 1'b0;
  logic [7:0] irq_ack = 8'h00;
  logic fire = 1'b0;
  logic [2:0] fire_ch = 3'h0;
  logic [7:0] out_val = 8'h00;
  logic [7:0] dir_val = 8'hFF;
  logic wb_ack;
  logic evt_lu;
  logic evt_hu;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  logic [7:0] evt;
  logic [7:0] port_out;
  logic [7:0] port_dir;
  logic [7:0] pin;
  logic [7:0] pin_oe;
  logic [7:0] dma_req;
  logic [3:0] evt_cmp;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_lu = 0;
  int n_hu = 0;
  int n_cmp = 0;

  sdp_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dma_i(wb_dma), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_dat), .evt_i(evt), .irq_ack_i(irq_ack), .port_out_i(port_out), .port_dir_i(port_dir),
    .pin_o(pin), .pin_oe_o(pin_oe), .evt_low_unf_o(evt_lu), .evt_high_unf_o(evt_hu), .evt_cmp_o(evt_cmp),
    .dma_req_o(dma_req));

  sdp_far_model far (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .ch_i(fire_ch), .out_val_i(out_val),
    .dir_val_i(dir_val), .evt_o(evt), .port_out_o(port_out), .port_dir_o(port_dir));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // Counts event pulses and cuts a hang short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (!rst_i) begin
      n_lu <= n_lu + int'(evt_lu);
      n_hu <= n_hu + int'(evt_hu);
      n_cmp <= n_cmp + $countones(evt_cmp);
    end
    if (cycles == 15000) begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic we, input logic [5:0] idx, input logic [7:0] wd, input logic dma);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, wd}};
    wb_dma <= dma;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: ack %h expected %h", $time, wb_ack, 1'b1);
    end
    rd = wb_dat;
    wb_req <= '0;
    wb_dma <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    acc(1'b1, idx, wd, 1'b0);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00, 1'b0);
    chk(rd, {24'h0, exp});
  endtask

  task automatic tick(input logic [2:0] ch);
    fire <= 1'b1;
    fire_ch <= ch;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(SDP_IDX_CLK, 8'h00);
    rdc(SDP_IDX_LPER, 8'hFF);
    rdc(SDP_IDX_HCNT, 8'h00);
    rdc(SDP_IDX_FLAGS, 8'h00);
    rdc(6'h03, 8'h00);
    wr(SDP_IDX_LCNT, 8'h05);
    tick(3'h0);
    rdc(SDP_IDX_LCNT, 8'h05);
    wr(SDP_IDX_OVAL, 8'h3C);
    rdc(SDP_IDX_OVAL, 8'h3C);
    wr(SDP_IDX_OEN, 8'h0F);
    out_val <= 8'hA0;
    dir_val <= 8'h5A;
    repeat (2) @(posedge clk_i);
    chk(32'(pin), 32'hAC);
    chk(32'(pin_oe), 32'h5A);
    wr(SDP_IDX_OEN, 8'hF0);
    chk(32'(pin), 32'h30);
    wr(SDP_IDX_OVAL, 8'h00);
    wr(SDP_IDX_MODE, 8'h02);
    wr(SDP_IDX_LPER, 8'h03);
    wr(SDP_IDX_HPER, 8'h04);
    wr(SDP_IDX_LCNT, 8'h00);
    for (int x = 0; x < 8; x++) begin
      wr(SDP_IDX_CMP0 + 6'(x), (x < 2) ? 8'h02 : 8'hF0);
    end
    wr(SDP_IDX_CLK, 8'h0D);
    repeat (2) tick(3'h5);
    rdc(SDP_IDX_LCNT, 8'h02);
    rdc(SDP_IDX_HCNT, 8'h03);
    wr(SDP_IDX_LPER, 8'h05);
    repeat (2) tick(3'h5);
    rdc(SDP_IDX_LCNT, 8'h00);
    rdc(SDP_IDX_OVAL, 8'h11);
    rdc(SDP_IDX_FLAGS, 8'h13);
    chk(32'(dma_req), 32'h13);
    tick(3'h5);
    rdc(SDP_IDX_LCNT, 8'h05);
    rdc(SDP_IDX_OVAL, 8'h10);
    chk(32'(pin), 32'h10);
    chk(32'(n_lu), 32'h2);
    chk(32'(n_hu), 32'h1);
    chk(32'(n_cmp), 32'h1);
    acc(1'b1, SDP_IDX_LPER, 8'h05, 1'b1);
    rdc(SDP_IDX_FLAGS, 8'h12);
    wr(SDP_IDX_FLAGS, 8'h02);
    rdc(SDP_IDX_FLAGS, 8'h10);
    irq_ack <= 8'h10;
    @(posedge clk_i);
    irq_ack <= 8'h00;
    rdc(SDP_IDX_FLAGS, 8'h00);
    chk(32'(dma_req), 32'h0);
    repeat (4) tick(3'h5);
    rdc(SDP_IDX_FLAGS, 8'h12);
    acc(1'b0, SDP_IDX_CMP0, 8'h00, 1'b1);
    rdc(SDP_IDX_FLAGS, 8'h02);
    wr(SDP_IDX_CMD, {4'h0, 2'(SDP_CMD_RESTART), SDP_TGT_LOW});
    rdc(SDP_IDX_CMD, 8'h00);
    rdc(SDP_IDX_LCNT, 8'h00);
    rdc(SDP_IDX_OVAL, 8'h10);
    rdc(SDP_IDX_HCNT, 8'h01);
    wr(SDP_IDX_OVAL, 8'hFF);
    rdc(SDP_IDX_OVAL, 8'h10);
    wr(SDP_IDX_CMD, {4'h0, 2'(SDP_CMD_RESET), 2'b11});
    rdc(SDP_IDX_LPER, 8'h05);
    wr(SDP_IDX_MODE, 8'h03);
    tick(3'h5);
    rdc(SDP_IDX_HCNT, 8'h01);
    wr(SDP_IDX_MODE, 8'h02);
    for (int c = 0; c < 8; c++) begin
      wr(SDP_IDX_CLK, {5'h01, 3'(c)});
      wr(SDP_IDX_LCNT, 8'h20);
      wr(SDP_IDX_HCNT, 8'h20);
      tick(3'(c + 1));
      tick(3'(c));
      rdc(SDP_IDX_LCNT, 8'h1F);
      rdc(SDP_IDX_HCNT, 8'h1F);
    end
    wr(SDP_IDX_CLK, 8'h00);
    tick(3'h7);
    rdc(SDP_IDX_LCNT, 8'h1F);
    wr(SDP_IDX_CMD, {4'h0, 2'(SDP_CMD_RESET), SDP_TGT_HIGH});
    rdc(SDP_IDX_LPER, 8'hFF);
    rdc(SDP_IDX_MODE, 8'h00);
    rdc(SDP_IDX_OEN, 8'h00);
    // Each prescale runs for eight of its periods, so exactly eight ticks land.
    for (int c = 1; c < 8; c++) begin
      int div;
      div = (c < 5) ? (1 << (c - 1)) : (16 << (2 * (c - 4)));
      wr(SDP_IDX_MODE, (c == 7) ? 8'h01 : 8'h00);
      wr(SDP_IDX_LCNT, 8'h20);
      wr(SDP_IDX_HCNT, 8'h20);
      wr(SDP_IDX_CLK, 8'(c));
      repeat (8 * div - 3) @(posedge clk_i);
      wr(SDP_IDX_CLK, 8'h00);
      rdc(SDP_IDX_LCNT, 8'h18);
      rdc(SDP_IDX_HCNT, (c == 7) ? 8'h00 : 8'h20);
    end
    summarize();
  end
endmodule

`default_nettype wire
